// >>> design/pmdlc_top.sv
// Top of the four-lane medium-dependent control and status block.
`default_nettype none
`include "pmdlc_defs.svh"
// Summary of operation
// RL1 - Transmit bits pass in order per lane
// RL2 - Receive bits delivered per lane intact
// RL3 - Transmit one is high optical power
// RL4 - Received high power becomes logical one
// RL5 - Exactly four lanes, zero to three
// RL6 - Upper layer feeds four lanes continuously
// RL7 - Device feeds four receive lanes continuously
// RL8 - Global detect reported on service output
// RL9 - Global detect covers all four lanes
// RL10 - Detect is one bit, OK or FAIL
// RL11 - Upper layer ignores data on FAIL
// RL12 - Detect OK does not prove data
// RL13 - Optional per-lane detect status
// RL14 - Reset control returns sublayer to start
// RL15 - Global disable darkens all transmitters
// RL16 - Lane disable darkens only that lane
// RL17 - Summary fault on any local fault
// RL18 - Transmit fault on any transmit lane
// RL19 - Receive fault on any receive lane
// RL20 - Management registers and access both present
// RL21 - Fast wake idle only, no deep sleep
// RL22 - Reset at control one bit fifteen
// RL23 - Disables at bits zero through four
// RL24 - Fault bits seven, eleven and ten
// RL25 - Detects at bits zero through four
// RL26 - Global detect is AND of lanes
// RL27 - One-cycle event on detect change
module pmdlc_top (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // Register port.
   input wire logic [7:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   // Service interface lanes.
   input wire pmdlc_pkg::pmdlc_lanes_t i_tx_bit,
   output logic [3:0] o_rx_bit,
   output logic o_signal_ok,
   output logic o_signal_event,
   // Medium side.
   output logic [3:0] o_tx_light,
   input wire pmdlc_pkg::pmdlc_lanes_t i_rx_light,
   input wire pmdlc_pkg::pmdlc_lanes_t i_rx_det,
   input wire pmdlc_pkg::pmdlc_lanes_t i_tx_fault,
   input wire pmdlc_pkg::pmdlc_lanes_t i_rx_fault,
   // Low-power idle.
   input wire logic i_lpi_req,
   output logic o_lpi_active
);
   import pmdlc_pkg::*;

   // ==========================================================================
   // Synchronisers and shared state.
   pmdlc_bus_t bus;
   pmdlc_fault_t flt_m_q;
   pmdlc_fault_t flt_q;
   logic lpi_m_q;
   logic lpi_q;
   logic [4:0] txdis_q;
   logic [3:0] srst_cnt_q;
   logic srst_q;
   logic [3:0] lane_det;
   logic [3:0] lane_tx;
   logic [3:0] lane_rx;
   logic [3:0] lane_off;
   logic gdet_q;
   logic gdet_d;
   logic evt_q;
   logic [15:0] rdata_q;
   logic [15:0] rdata_d;
   logic lpi_act_q;
   logic [4:0] idx;
   logic flt_any;

   assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
   assign idx = bus.addr[6:2];

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         flt_m_q <= '0;
         flt_q <= '0;
         lpi_m_q <= 1'b0;
         lpi_q <= 1'b0;
      end else begin
         flt_m_q <= '{tx_fault: i_tx_fault, rx_fault: i_rx_fault};
         flt_q <= flt_m_q;
         lpi_m_q <= i_lpi_req;
         lpi_q <= lpi_m_q;
      end
   end

   // ==========================================================================
   // Sublayer reset, self-clearing after a short hold. [RL14] [RL22]
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         srst_cnt_q <= 4'h0;
         srst_q <= 1'b0;
      end else if (bus.wr && idx == `PMDLC_IDX_CTRL1 && bus.wdata[`PMDLC_CTRL1_RESET]) begin
         srst_cnt_q <= `PMDLC_RESET_HOLD;
         srst_q <= 1'b1;
      end else if (srst_cnt_q != 4'h0) begin
         srst_cnt_q <= srst_cnt_q - 4'h1;
         srst_q <= 1'b1;
      end else begin
         srst_q <= 1'b0;
      end
   end

   // Transmit disable register: global at bit 0, lanes at bits 1 to 4. [RL23] [RL20]
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         txdis_q <= `PMDLC_TXDIS_RST;
      end else if (srst_q) begin
         txdis_q <= `PMDLC_TXDIS_RST;
      end else if (bus.wr && idx == `PMDLC_IDX_TXDIS) begin
         txdis_q <= bus.wdata[4:0];
      end
   end

   // ==========================================================================
   // Four independent lanes. [RL5]
   genvar g;
   generate
      for (g = 0; g < `PMDLC_LANES; g++) begin : g_lane
         // Global disable forces every lane off. [RL15]
         assign lane_off[g] = txdis_q[`PMDLC_GLOBAL_BIT] | txdis_q[`PMDLC_LANE_LSB + g];
         pmdlc_lane u_lane (
            .i_ref_clk(i_ref_clk),
            .i_rst_b(i_rst_b),
            .i_srst(srst_q),
            .i_tx_bit(i_tx_bit[g]),
            .i_tx_off(lane_off[g]),
            .o_tx_light(lane_tx[g]),
            .i_rx_light(i_rx_light[g]),
            .i_rx_det(i_rx_det[g]),
            .o_rx_bit(lane_rx[g]),
            .o_det(lane_det[g])
         );
      end
   endgenerate

   // ==========================================================================
   // Global signal detect: one bit, OK only when every lane detects. [RL9] [RL10] [RL26]
   assign gdet_d = &lane_det;

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         gdet_q <= 1'b0;
         evt_q <= 1'b0;
      end else begin
         gdet_q <= gdet_d;
         // A pulse on every change drives the indication. [RL8] [RL27]
         evt_q <= gdet_d ^ gdet_q;
      end
   end

   // Fast-wake idle only; no deep-sleep state exists. [RL21]
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         lpi_act_q <= 1'b0;
      end else begin
         lpi_act_q <= lpi_q & ~srst_q;
      end
   end

   // ==========================================================================
   // Register read, data in the cycle after the strobe.
   assign flt_any = |flt_q.tx_fault | |flt_q.rx_fault;

   always_comb begin
      rdata_d = 16'h0000;
      unique case (idx)
         `PMDLC_IDX_CTRL1: rdata_d[`PMDLC_CTRL1_RESET] = srst_q;
         `PMDLC_IDX_STAT1: rdata_d[`PMDLC_STAT1_FAULT] = flt_any; // [RL17] [RL24]
         `PMDLC_IDX_STAT2: begin
            rdata_d[`PMDLC_STAT2_TXFLT] = |flt_q.tx_fault; // [RL18] [RL24]
            rdata_d[`PMDLC_STAT2_RXFLT] = |flt_q.rx_fault; // [RL19] [RL24]
         end
         `PMDLC_IDX_TXDIS: rdata_d[4:0] = txdis_q;
         `PMDLC_IDX_SIGDET: rdata_d[4:0] = {lane_det, gdet_q}; // [RL25] [RL13]
         `PMDLC_IDX_FAULTSRC: rdata_d[7:0] = flt_q;
         default: rdata_d = 16'h0000;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rdata_q <= 16'h0000;
      end else if (bus.rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 16'h0000;
      end
   end

   assign o_rdata = rdata_q;
   assign o_rx_bit = lane_rx;
   assign o_tx_light = lane_tx;
   assign o_signal_ok = gdet_q;
   assign o_signal_event = evt_q;
   assign o_lpi_active = lpi_act_q;

   // ==========================================================================
   // Checks.
   sequence det_change_s;
      gdet_q != $past(gdet_q);
   endsequence

   property evt_on_change_p;
      @(posedge i_ref_clk) disable iff (!i_rst_b)
      det_change_s |-> o_signal_event;
   endproperty

   global_disable_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL15]
      txdis_q[0] |=> o_tx_light == 4'h0)
      else $error("Transmitters lit under global disable.");

   lane_disable_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL16]
      (!txdis_q[0] && !srst_q && txdis_q[1]) |=> o_tx_light[0] == 1'b0)
      else $error("Lane 0 lit while disabled.");

   tx_pass_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL1]
      (lane_off == 4'h0 && !srst_q) |=> o_tx_light == $past(i_tx_bit))
      else $error("Transmit bits not passed.");

   rx_pass_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL2]
      ##2 o_rx_bit == $past(i_rx_light, 2))
      else $error("Receive bits not delivered.");

   global_and_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL26]
      o_signal_ok == $past(&lane_det))
      else $error("Global detect is not the AND of lanes.");

   change_evt_a: assert property (evt_on_change_p) // [RL27]
      else $error("No event on detect change.");

   evt_only_change_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL27]
      o_signal_event |-> gdet_q != $past(gdet_q))
      else $error("Event without detect change.");

   reset_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL14]
      (i_wr && idx == `PMDLC_IDX_CTRL1 && i_wdata[15]) |=> srst_q [*8])
      else $error("Sublayer reset not held.");

   fault_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL17]
      (i_rd && idx == `PMDLC_IDX_STAT1) |=> o_rdata[7] == $past(flt_any))
      else $error("Fault flag read wrong.");

   // ==========================================================================
   // Lane isolation, transmit polarity, sublayer reset, idle, detect and register access checks.
   lane1_disable_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL16]
      (!txdis_q[0] && !srst_q && txdis_q[2]) |=> o_tx_light[1] == 1'b0)
      else $error("Lane 1 lit while disabled.");

   lane2_disable_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL16]
      (!txdis_q[0] && !srst_q && txdis_q[3]) |=> o_tx_light[2] == 1'b0)
      else $error("Lane 2 lit while disabled.");

   lane3_disable_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL16]
      (!txdis_q[0] && !srst_q && txdis_q[4]) |=> o_tx_light[3] == 1'b0)
      else $error("Lane 3 lit while disabled.");

   lane_isolate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL16]
      (txdis_q == 5'h02 && !srst_q) |=> o_tx_light[3:1] == $past(i_tx_bit[3:1]))
      else $error("Lane 0 disable touched other lanes.");

   tx_one_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL3]
      (!lane_off[0] && !srst_q && i_tx_bit[0]) |=> o_tx_light[0])
      else $error("Transmit one not sent as high power.");

   tx_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL3]
      (i_tx_bit == 4'h0) |=> o_tx_light == 4'h0)
      else $error("Transmit zero sent as high power.");

   srst_dark_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL14]
      srst_q |=> o_tx_light == 4'h0)
      else $error("Transmitters lit during sublayer reset.");

   srst_txdis_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL14]
      srst_q |=> txdis_q == 5'h00)
      else $error("Disable register kept through sublayer reset.");

   srst_lpi_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL14]
      srst_q |=> !o_lpi_active)
      else $error("Idle active during sublayer reset.");

   srst_start_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL22]
      (i_wr && idx == `PMDLC_IDX_CTRL1 && i_wdata[15]) |=> (srst_q && srst_cnt_q == 4'hF))
      else $error("Sublayer reset not started by control bit.");

   srst_end_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL14]
      (srst_q && srst_cnt_q == 4'h0 && !(i_wr && idx == `PMDLC_IDX_CTRL1 && i_wdata[15]))
      |=> !srst_q)
      else $error("Sublayer reset did not end.");

   lpi_follow_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL21]
      (lpi_q && !srst_q) |=> o_lpi_active)
      else $error("Fast-wake idle not entered.");

   det_fail_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL9]
      (lane_det != 4'hF) |=> !o_signal_ok)
      else $error("Global detect OK with a lane dark.");

   det_ok_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL26]
      (lane_det == 4'hF) |=> o_signal_ok)
      else $error("Global detect FAIL with all lanes lit.");

   rdata_idle_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL20]
      !i_rd |=> o_rdata == 16'h0000)
      else $error("Read data shown without a read.");

   ctrl_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL22]
      (i_rd && idx == `PMDLC_IDX_CTRL1) |=> o_rdata == {$past(srst_q), 15'h0000})
      else $error("Control register read wrong.");

   stat2_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL24]
      (i_rd && idx == `PMDLC_IDX_STAT2) |=> o_rdata ==
      {4'h0, $past(|flt_q.tx_fault), $past(|flt_q.rx_fault), 10'h000})
      else $error("Second status register read wrong.");

   sigdet_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL25]
      (i_rd && idx == `PMDLC_IDX_SIGDET) |=> o_rdata ==
      {11'h000, $past(lane_det), $past(gdet_q)})
      else $error("Signal detect register read wrong.");

   txdis_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL23]
      (i_rd && idx == `PMDLC_IDX_TXDIS) |=> o_rdata == {11'h000, $past(txdis_q)})
      else $error("Disable register read wrong.");

   txdis_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL23]
      (i_wr && idx == `PMDLC_IDX_TXDIS && !srst_q) |=> txdis_q == $past(i_wdata[4:0]))
      else $error("Disable register write lost.");

   txdis_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_b) // [RL23]
      (!srst_q && !(i_wr && idx == `PMDLC_IDX_TXDIS)) |=> $stable(txdis_q))
      else $error("Disable register changed without a write.");
endmodule
`default_nettype wire

// >>> design/pmdlc_defs.svh
// Register offsets, field positions and reset values of the lane control and status block.
`ifndef PMDLC_DEFS_SVH
`define PMDLC_DEFS_SVH
// ==========================================================================
// Register indices (byte address is four times the index).
`define PMDLC_IDX_CTRL1 5'h00
`define PMDLC_IDX_STAT1 5'h01
`define PMDLC_IDX_STAT2 5'h08
`define PMDLC_IDX_TXDIS 5'h09
`define PMDLC_IDX_SIGDET 5'h0A
`define PMDLC_IDX_FAULTSRC 5'h10
// ==========================================================================
// Field positions.
`define PMDLC_CTRL1_RESET 15
`define PMDLC_STAT1_FAULT 7
`define PMDLC_STAT2_TXFLT 11
`define PMDLC_STAT2_RXFLT 10
`define PMDLC_GLOBAL_BIT 0
`define PMDLC_LANE_LSB 1
`define PMDLC_LANES 4
// ==========================================================================
// Reset values and counts.
`define PMDLC_TXDIS_RST 5'h00
`define PMDLC_RESET_HOLD 4'hF
`endif

// >>> design/pmdlc_pkg.sv
// Types shared by the lane control and status block.
`default_nettype none
package pmdlc_pkg;
   typedef logic [3:0] pmdlc_lanes_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } pmdlc_bus_t;
   typedef struct packed {
      pmdlc_lanes_t tx_fault;
      pmdlc_lanes_t rx_fault;
   } pmdlc_fault_t;
endpackage
`default_nettype wire

// >>> design/pmdlc_lane.sv
// One lane of the data path: two-flop detect synchroniser and bit passing.
`default_nettype none
`include "pmdlc_defs.svh"
module pmdlc_lane (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_srst,
   // Transmit path.
   input wire logic i_tx_bit,
   input wire logic i_tx_off,
   output logic o_tx_light,
   // Receive path.
   input wire logic i_rx_light,
   input wire logic i_rx_det,
   output logic o_rx_bit,
   output logic o_det
);
   logic det_m_q;
   logic det_q;
   logic rx_m_q;
   logic rx_q;
   logic tx_q;

   // High power carries a one; a disabled lane stays dark. [RL1] [RL3] [RL16]
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tx_q <= 1'b0;
      end else if (i_srst) begin
         tx_q <= 1'b0;
      end else begin
         tx_q <= i_tx_bit & ~i_tx_off;
      end
   end

   // High received power is delivered as one, lane kept in place. [RL2] [RL4] [RL7]
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rx_m_q <= 1'b0;
         rx_q <= 1'b0;
      end else begin
         rx_m_q <= i_rx_light;
         rx_q <= rx_m_q;
      end
   end

   // Per-lane detect, set only from its own lane. [RL13]
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         det_m_q <= 1'b0;
         det_q <= 1'b0;
      end else begin
         det_m_q <= i_rx_det;
         det_q <= det_m_q;
      end
   end

   assign o_tx_light = tx_q;
   assign o_rx_bit = rx_q;
   assign o_det = det_q;
endmodule
`default_nettype wire

// >>> bench/pmdlc_pma_model.sv
// Behavioural model of the attachment logic that sits above the four lanes.
`default_nettype none
module pmdlc_pma_model (
   // Clock and reset.
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   // Receive lanes and detect from the block.
   input wire logic [3:0] i_rx_bit,
   input wire logic i_signal_ok,
   // Transmit lanes toward the block.
   output var pmdlc_pkg::pmdlc_lanes_t o_tx_bit,
   output var pmdlc_pkg::pmdlc_lanes_t o_tx_prev,
   output var logic [3:0] o_rx_keep
);
   timeunit 1ns;
   timeprecision 1ps;
   import pmdlc_pkg::*;
   // ======================================================================
   // Streams
   // A new value goes out on every rising edge so that dropped or stuck bits show.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_tx_bit <= 4'h0;
         o_tx_prev <= 4'h0;
      end else begin
         o_tx_bit <= o_tx_bit + 4'h5;
         o_tx_prev <= o_tx_bit;
      end
   end
   // Received bits are kept only while detect reads OK; detect alone is not trusted.
   always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rx_keep <= 4'h0;
      end else if (i_signal_ok) begin
         o_rx_keep <= i_rx_bit;
      end
   end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the four-lane control and status block.
`default_nettype none
`include "pmdlc_defs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import pmdlc_pkg::*;
   logic i_ref_clk, i_rst_b, i_wr, i_rd, i_lpi_req, o_signal_ok, o_signal_event, o_lpi_active;
   logic [7:0] i_addr;
   logic [15:0] i_wdata, o_rdata;
   logic [3:0] o_rx_bit, o_tx_light, rx_keep;
   pmdlc_lanes_t i_tx_bit, tx_prev, i_rx_light, i_rx_det, i_tx_fault, i_rx_fault;
   int errors = 0;
   int comparisons = 0;
   pmdlc_top i_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_tx_bit(i_tx_bit),
      .o_rx_bit(o_rx_bit), .o_signal_ok(o_signal_ok), .o_signal_event(o_signal_event),
      .o_tx_light(o_tx_light), .i_rx_light(i_rx_light), .i_rx_det(i_rx_det),
      .i_tx_fault(i_tx_fault), .i_rx_fault(i_rx_fault), .i_lpi_req(i_lpi_req),
      .o_lpi_active(o_lpi_active));
   pmdlc_pma_model i_pma (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_rx_bit(o_rx_bit),
      .i_signal_ok(o_signal_ok), .o_tx_bit(i_tx_bit), .o_tx_prev(tx_prev),
      .o_rx_keep(rx_keep));
   // ======================================================================
   // Shared tasks
   task automatic end_sim();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask
   task automatic wr(input logic [4:0] idx, input logic [15:0] d);
      @(posedge i_ref_clk);
      i_addr <= {1'b0, idx, 2'b00};
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [4:0] idx, input logic [15:0] exp);
      @(posedge i_ref_clk);
      i_addr <= {1'b0, idx, 2'b00};
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 chk(o_rdata, exp);
   endtask
   // ======================================================================
   // Scenarios
   task automatic t_reset();
      rdc(`PMDLC_IDX_TXDIS, 16'h0000);
      rdc(`PMDLC_IDX_SIGDET, 16'h0000);
      rdc(`PMDLC_IDX_STAT1, 16'h0000);
      rdc(5'h1F, 16'h0000);
   endtask
   task automatic t_tx();
      logic [4:0] dis [6] = '{5'h00, 5'h02, 5'h04, 5'h08, 5'h10, 5'h01};
      for (int k = 0; k < 6; k++) begin
         wr(`PMDLC_IDX_TXDIS, {11'h000, dis[k]});
         rdc(`PMDLC_IDX_TXDIS, {11'h000, dis[k]});
         tick(2);
         repeat (4) begin
            tick(1);
            chk(16'(o_tx_light), 16'(tx_prev & ~(dis[k][0] ? 4'hF : dis[k][4:1])));
         end
      end
      wr(`PMDLC_IDX_TXDIS, 16'h0000);
   endtask
   task automatic t_rx();
      logic [3:0] pat [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'hA, 4'h5};
      foreach (pat[k]) begin
         i_rx_light <= pat[k];
         tick(3);
         chk(16'(o_rx_bit), 16'(pat[k]));
      end
   endtask
   task automatic t_det();
      i_rx_det <= 4'hF;
      tick(2);
      chk(16'(o_signal_ok), 16'h0000);
      tick(1);
      chk(16'({o_signal_ok, o_signal_event}), 16'h0003);
      tick(1);
      chk(16'({o_signal_ok, o_signal_event}), 16'h0002);
      tick(1);
      chk(16'(o_signal_event), 16'h0000);
      rdc(`PMDLC_IDX_SIGDET, 16'h001F);
      for (int g = 0; g < 4; g++) begin
         i_rx_det <= 4'hF & ~(4'h1 << g);
         tick(4);
         chk(16'(o_signal_ok), 16'h0000);
         rdc(`PMDLC_IDX_SIGDET, 16'({4'hF & ~(4'h1 << g), 1'b0}));
         i_rx_det <= 4'hF;
         tick(4);
      end
   endtask
   task automatic t_flt();
      for (int g = 0; g < 4; g++) begin
         i_tx_fault <= 4'h1 << g;
         tick(4);
         rdc(`PMDLC_IDX_STAT1, 16'h0080);
         rdc(`PMDLC_IDX_STAT2, 16'h0800);
         rdc(`PMDLC_IDX_FAULTSRC, 16'({4'h1 << g, 4'h0}));
         i_tx_fault <= 4'h0;
         i_rx_fault <= 4'h1 << g;
         tick(4);
         rdc(`PMDLC_IDX_STAT2, 16'h0400);
         rdc(`PMDLC_IDX_STAT1, 16'h0080);
         i_rx_fault <= 4'h0;
      end
      tick(4);
      rdc(`PMDLC_IDX_STAT1, 16'h0000);
   endtask
   task automatic t_srst();
      i_lpi_req <= 1'b1;
      tick(4);
      chk(16'(o_lpi_active), 16'h0001);
      wr(`PMDLC_IDX_TXDIS, 16'h001E);
      wr(`PMDLC_IDX_CTRL1, 16'h8000);
      rdc(`PMDLC_IDX_CTRL1, 16'h8000);
      chk(16'({o_tx_light, o_lpi_active}), 16'h0000);
      i_lpi_req <= 1'b0;
      tick(20);
      rdc(`PMDLC_IDX_TXDIS, 16'h0000);
      rdc(`PMDLC_IDX_CTRL1, 16'h0000);
   endtask
   // ======================================================================
   // Clock, main sequence and watchdog
   initial begin
      i_ref_clk = 1'b0;
      forever #5 i_ref_clk = ~i_ref_clk;
   end
   initial begin
      {i_rst_b, i_wr, i_rd, i_lpi_req, i_addr, i_wdata} = '0;
      {i_rx_light, i_rx_det, i_tx_fault, i_rx_fault} = '0;
      repeat (2) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      t_reset();
      t_tx();
      t_rx();
      t_det();
      t_flt();
      t_srst();
      end_sim();
   end
   initial begin
      #200000;
      errors++;
      end_sim();
   end
endmodule
`default_nettype wire
